//--- inc/psdc_params.svh
// Behaviour
// - The block keeps a one-bit flag saying the shader or colour stage may discard pixels or samples for reasons other than depth or stencil tests.
// - Clip-distance clipping is done fully in hardware, so it never needs the kill flag.
// - The two-bit computed-depth field means no shader depth at code 0 and unbounded shader depth at code 1.
// - Code 2 of the computed-depth field means shader depth is never less than the source depth.
// - Code 3 of the computed-depth field means shader depth is never greater than the source depth.
// - Early depth/stencil code 0 makes tests look post-shader but lets the shader be skipped for failing pixels.
// - Code 1 makes tests look post-shader and always runs the shader for failing pixels, but never for pixels removed earlier.
// - Code 2 runs test and write before the shader, skips failing pixels, keeps writes for later-killed pixels and ignores shader depth.
`ifndef PSDC_PARAMS_SVH
`define PSDC_PARAMS_SVH

// ================================================================
// register offsets
`define PSDC_CMD_OFFSET   32'h0000_0000
`define PSDC_STAT_OFFSET  32'h0000_0004

// ================================================================
// field positions
`define PSDC_KILL_BIT     25
`define PSDC_DEPTH_MSB    23
`define PSDC_DEPTH_LSB    22
`define PSDC_DS_MSB       21
`define PSDC_DS_LSB       20
`define PSDC_RTIND_BIT    5
`define PSDC_VIOL_BIT     0
`define PSDC_EFF_MSB      3
`define PSDC_EFF_LSB      2

// ================================================================
// reset values
`define PSDC_KILL_RST     1'b0
`define PSDC_RTIND_RST    1'b0
`define PSDC_VIOL_RST     1'b0

`endif

//--- inc/psdc_pkg.sv
package psdc_pkg;

  typedef enum logic [1:0] {
    shader_depth_none,
    shader_depth_unbounded,
    shader_depth_not_less,
    shader_depth_not_greater
  } depth_mode_e;

  typedef enum logic [1:0] {
    ds_test_post_shader_skippable,
    ds_test_post_shader_always_run,
    ds_test_pre_shader,
    ds_test_reserved
  } ds_ctrl_e;

endpackage : psdc_pkg

//--- core/pixel_route.sv
`timescale 1ns/1ps
`default_nettype none
module pixel_route (
  input  wire logic                pclk,
  input  wire logic                presetn,
  input  wire logic                kill_possible,
  input  wire psdc_pkg::depth_mode_e depth_mode,
  input  wire psdc_pkg::ds_ctrl_e  ds_ctrl,
  input  wire logic                pix_valid,
  input  wire logic                pix_live,
  input  wire logic                pix_ds_pass,
  output logic                     out_valid,
  output logic                     out_dispatch,
  output logic                     out_ds_early,
  output logic                     out_ds_early_write,
  output logic                     out_use_shader_depth,
  output logic                     out_depth_not_less,
  output logic                     out_depth_not_greater
);
  import psdc_pkg::*;

  logic dispatch_next;
  logic early_next;
  logic early_wr_next;
  logic use_sd_next;
  logic cull_ok;

  always_comb begin
    cull_ok       = !kill_possible && (depth_mode == shader_depth_none);
    dispatch_next = pix_live;
    early_next    = 1'b0;
    early_wr_next = 1'b0;
    use_sd_next   = (depth_mode != shader_depth_none);
    case (ds_ctrl)
      ds_test_post_shader_skippable: begin
        dispatch_next = pix_live && (pix_ds_pass || !cull_ok);
      end
      ds_test_post_shader_always_run: begin
        dispatch_next = pix_live;
      end
      ds_test_pre_shader: begin
        dispatch_next = pix_live && pix_ds_pass;
        early_next    = 1'b1;
        early_wr_next = pix_live && pix_ds_pass;
        use_sd_next   = 1'b0;
      end
      default: begin
        // reserved code: the conservative choice is to shade every live pixel
        dispatch_next = pix_live;
      end
    endcase
    if (!pix_valid) begin
      dispatch_next = 1'b0;
      early_next    = 1'b0;
      early_wr_next = 1'b0;
      use_sd_next   = 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      out_valid             <= 1'b0;
      out_dispatch          <= 1'b0;
      out_ds_early          <= 1'b0;
      out_ds_early_write    <= 1'b0;
      out_use_shader_depth  <= 1'b0;
      out_depth_not_less    <= 1'b0;
      out_depth_not_greater <= 1'b0;
    end else begin
      out_valid             <= pix_valid;
      out_dispatch          <= dispatch_next;
      out_ds_early          <= early_next;
      out_ds_early_write    <= early_wr_next;
      out_use_shader_depth  <= use_sd_next;
      out_depth_not_less    <= use_sd_next &&
                               (depth_mode == shader_depth_not_less);
      out_depth_not_greater <= use_sd_next &&
                               (depth_mode == shader_depth_not_greater);
    end
  end
endmodule : pixel_route
`default_nettype wire

//--- core/pixel_shader_depth_control.sv
`timescale 1ns/1ps
`default_nettype none
`include "psdc_params.svh"
module pixel_shader_depth_control (
  input  wire logic                pclk,
  input  wire logic                presetn,
  input  wire logic                psel,
  input  wire logic                penable,
  input  wire logic                pwrite,
  input  wire logic [31:0]         paddr,
  input  wire logic [31:0]         pwdata,
  output logic [31:0]              prdata,
  output logic                     pready,
  output logic                     pslverr,
  input  wire logic                pix_valid,
  input  wire logic                pix_covered,
  input  wire logic                pix_clip_reject,
  input  wire logic                pix_ds_pass,
  output logic                     out_valid,
  output logic                     out_dispatch,
  output logic                     out_ds_early,
  output logic                     out_ds_early_write,
  output logic                     out_use_shader_depth,
  output logic                     out_depth_not_less,
  output logic                     out_depth_not_greater,
  output logic                     kill_possible,
  output psdc_pkg::depth_mode_e    depth_mode,
  output psdc_pkg::ds_ctrl_e       ds_ctrl,
  output logic                     rt_indep_raster,
  output logic                     state_violation
);
  import psdc_pkg::*;

  // ================================================================
  // bus decode
  logic        access;
  logic        hit_cmd;
  logic        hit_stat;
  logic        wr_cmd;
  logic        wr_stat;
  logic        viol_set;
  logic        viol_clr;
  logic        pix_live;
  depth_mode_e depth_reg;
  depth_mode_e depth_eff;
  ds_ctrl_e    ds_reg;
  logic        kill_reg;
  logic        rtind_reg;
  logic        viol_reg;

  assign access   = psel && penable;
  assign hit_cmd  = (paddr == `PSDC_CMD_OFFSET);
  assign hit_stat = (paddr == `PSDC_STAT_OFFSET);
  assign wr_cmd   = access && pwrite && hit_cmd;
  assign wr_stat  = access && pwrite && hit_stat;
  assign pready   = 1'b1;
  assign pslverr  = access && !hit_cmd && !hit_stat;

  always_comb begin
    prdata = 32'h0000_0000;
    if (hit_cmd) begin
      prdata[`PSDC_KILL_BIT]                  = kill_reg;
      prdata[`PSDC_DEPTH_MSB:`PSDC_DEPTH_LSB] = depth_reg;
      prdata[`PSDC_DS_MSB:`PSDC_DS_LSB]       = ds_reg;
      prdata[`PSDC_RTIND_BIT]                 = rtind_reg;
    end else if (hit_stat) begin
      prdata[`PSDC_VIOL_BIT]                  = viol_reg;
      prdata[`PSDC_EFF_MSB:`PSDC_EFF_LSB]     = depth_eff;
    end
  end

  // ================================================================
  // state capture
  // capture on command
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      kill_reg  <= `PSDC_KILL_RST;
      depth_reg <= shader_depth_none;
      ds_reg    <= ds_test_post_shader_skippable;
      rtind_reg <= `PSDC_RTIND_RST;
    end else if (wr_cmd) begin
      kill_reg  <= pwdata[`PSDC_KILL_BIT];
      depth_reg <= depth_mode_e'(pwdata[`PSDC_DEPTH_MSB:`PSDC_DEPTH_LSB]);
      ds_reg    <= ds_ctrl_e'(pwdata[`PSDC_DS_MSB:`PSDC_DS_LSB]);
      rtind_reg <= pwdata[`PSDC_RTIND_BIT];
    end
  end

  // ================================================================
  // illegal bounded depth with rt-independent rasterization
  // flag bad programming
  assign viol_set = wr_cmd && pwdata[`PSDC_RTIND_BIT] &&
                    pwdata[`PSDC_DEPTH_MSB];
  assign viol_clr = wr_stat && pwdata[`PSDC_VIOL_BIT];

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      viol_reg <= `PSDC_VIOL_RST;
    end else begin
      // a new violation outranks a clear in the same cycle
      viol_reg <= viol_set || (viol_reg && !viol_clr);
    end
  end

  // bounds are only trusted when legal; dropping to unbounded is safe
  // degrade illegal bound
  always_comb begin
    depth_eff = depth_reg;
    if (rtind_reg && (depth_reg == shader_depth_not_less ||
                      depth_reg == shader_depth_not_greater)) begin
      depth_eff = shader_depth_unbounded;
    end
  end

  assign kill_possible   = kill_reg;
  assign depth_mode      = depth_eff;
  assign ds_ctrl         = ds_reg;
  assign rt_indep_raster = rtind_reg;
  assign state_violation = viol_reg;

  // ================================================================
  // per-pixel routing
  // clip rejects in hardware
  assign pix_live = pix_covered && !pix_clip_reject;

  pixel_route u_route (
    .pclk                  (pclk),
    .presetn               (presetn),
    .kill_possible         (kill_reg),
    .depth_mode            (depth_eff),
    .ds_ctrl               (ds_reg),
    .pix_valid             (pix_valid),
    .pix_live              (pix_live),
    .pix_ds_pass           (pix_ds_pass),
    .out_valid             (out_valid),
    .out_dispatch          (out_dispatch),
    .out_ds_early          (out_ds_early),
    .out_ds_early_write    (out_ds_early_write),
    .out_use_shader_depth  (out_use_shader_depth),
    .out_depth_not_less    (out_depth_not_less),
    .out_depth_not_greater (out_depth_not_greater)
  );

  // ================================================================
  // checks
  kill_capture_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    wr_cmd |=> kill_possible == $past(pwdata[`PSDC_KILL_BIT]))
    else $error("kill flag not captured from command");

  clip_hw_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    pix_valid && pix_clip_reject |=> out_valid && !out_dispatch
                                      && !out_ds_early_write)
    else $error("clip-rejected pixel was shaded");

  depth_none_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    pix_valid && depth_mode == shader_depth_none
      |=> !out_use_shader_depth && !out_depth_not_less
          && !out_depth_not_greater)
    else $error("shader depth used with no computed depth");

  bound_ge_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    pix_valid && depth_mode == shader_depth_not_less
      && ds_ctrl != ds_test_pre_shader
      |=> out_use_shader_depth && out_depth_not_less
          && !out_depth_not_greater)
    else $error("not-less depth bound missing");

  bound_le_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    pix_valid && depth_mode == shader_depth_not_greater
      && ds_ctrl != ds_test_pre_shader
      |=> out_use_shader_depth && out_depth_not_greater
          && !out_depth_not_less)
    else $error("not-greater depth bound missing");

  skip_mode_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    pix_valid && ds_ctrl == ds_test_post_shader_skippable
      |=> !out_ds_early
          && out_dispatch == $past(pix_live && (pix_ds_pass
             || kill_possible || depth_mode != shader_depth_none)))
    else $error("skippable post-shader routing wrong");

  run_mode_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    pix_valid && ds_ctrl == ds_test_post_shader_always_run
      |=> !out_ds_early && out_dispatch == $past(pix_live))
    else $error("always-run mode did not shade live pixel");

  pre_mode_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    pix_valid && ds_ctrl == ds_test_pre_shader
      |=> out_ds_early && !out_use_shader_depth
          && out_dispatch == $past(pix_live && pix_ds_pass)
          && out_ds_early_write == out_dispatch)
    else $error("pre-shader test routing wrong");

  state_hold_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    !wr_cmd |=> $stable(kill_possible) && $stable(ds_ctrl)
                && $stable(depth_mode))
    else $error("pipeline state changed without a command");

  viol_sticky_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    viol_set |=> state_violation && depth_mode != shader_depth_not_less
                 && depth_mode != shader_depth_not_greater)
    else $error("illegal bounded depth not caught");

endmodule : pixel_shader_depth_control
`default_nettype wire

//--- testbench/cmd_streamer_model.sv
`timescale 1ns/1ps
`default_nettype none
module cmd_streamer_model (
  input  wire logic        pclk,
  output logic             psel,
  output logic             penable,
  output logic             pwrite,
  output logic [31:0]      paddr,
  output logic [31:0]      pwdata,
  input  wire logic [31:0] prdata,
  input  wire logic        pready,
  input  wire logic        pslverr
);
  initial begin
    psel = 0;
    penable = 0;
    pwrite = 0;
    paddr = 0;
    pwdata = 0;
  end
  // kill from sources: discard, chroma key, alpha, mask
  // rt-independent forbids codes 2/3 unless told to break it
  function automatic logic [31:0] cmd(input logic [3:0] ksrc,
      input logic [1:0] dm, input logic [1:0] ds, input logic rt,
      input logic brk);
    logic [1:0] d;
    d = (rt && dm[1] && !brk) ? 2'h1 : dm;
    return {6'h0, |ksrc, 1'b0, d, ds, 14'h0, rt, 5'h0};
  endfunction : cmd
  // held until pready is seen; bus scrambled once released
  task automatic xfer(input logic w, input logic [31:0] a, d,
      output logic [31:0] r, output logic e);
    @(posedge pclk);
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    do @(posedge pclk); while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 0;
    penable <= 0;
    paddr <= ~a;
    pwdata <= ~d;
  endtask : xfer
endmodule : cmd_streamer_model
`default_nettype wire

//--- testbench/pixel_shader_depth_control_tb.sv
`timescale 1ns/1ps
`default_nettype none
module pixel_shader_depth_control_tb;
  import psdc_pkg::*;
  logic pclk = 0, presetn = 0, psel, penable, pwrite, pready, pslverr;
  logic [31:0] paddr, pwdata, prdata, r;
  logic pix_valid = 0, pix_covered = 0, pix_clip_reject = 0;
  logic pix_ds_pass = 0, e, rt_indep_raster, state_violation;
  logic out_valid, out_dispatch, out_ds_early, out_ds_early_write;
  logic out_use_shader_depth, out_depth_not_less, out_depth_not_greater;
  logic kill_possible;
  depth_mode_e depth_mode;
  ds_ctrl_e ds_ctrl;
  int error_cnt = 0, compares = 0, cyc = 0;
  logic [5:0] exp_q[$];
  always #10 pclk = ~pclk;
  pixel_shader_depth_control u_dut (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .pix_valid(pix_valid), .pix_covered(pix_covered),
    .pix_clip_reject(pix_clip_reject), .pix_ds_pass(pix_ds_pass),
    .out_valid(out_valid), .out_dispatch(out_dispatch),
    .out_ds_early(out_ds_early), .out_ds_early_write(out_ds_early_write),
    .out_use_shader_depth(out_use_shader_depth),
    .out_depth_not_less(out_depth_not_less),
    .out_depth_not_greater(out_depth_not_greater),
    .kill_possible(kill_possible), .depth_mode(depth_mode),
    .ds_ctrl(ds_ctrl), .rt_indep_raster(rt_indep_raster),
    .state_violation(state_violation));
  cmd_streamer_model u_cs (.pclk(pclk), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr));
  task automatic test_done();
    $display("checks %0d mismatches %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : test_done
  task automatic chk(input string n, input logic [31:0] x, y);
    compares++;
    if (x !== y) begin
      error_cnt++;
      $display("[ERR] %s exp %h got %h", n, x, y);
    end
  endtask : chk
  task automatic rd(input logic [31:0] a, output logic [31:0] d);
    u_cs.xfer(1'b0, a, 32'h0, d, e);
  endtask : rd
  task automatic wr(input logic [31:0] a, d);
    u_cs.xfer(1'b1, a, d, r, e);
  endtask : wr
  // ==========================================================
  // pixel driver and monitor
  task automatic pix(input logic k, input logic [1:0] m, s);
    logic c, q, p, lv, ds2;
    c = 1'($urandom);
    q = ($urandom % 4) == 0;
    p = 1'($urandom);
    lv = c & !q;
    ds2 = (s == 2'h2);
    @(posedge pclk);
    pix_valid <= 1;
    pix_covered <= c;
    pix_clip_reject <= q;
    pix_ds_pass <= p;
    exp_q.push_back({(s == 0) ? lv & (p | k | m != 0) : ds2 ? lv & p : lv,
      ds2, ds2 & lv & p, m != 0 && !ds2, m == 2 && !ds2, m == 3 && !ds2});
  endtask : pix
  always @(posedge pclk) begin
    cyc++;
    if (cyc > 20000) begin
      error_cnt++;
      test_done();
    end
    if (out_valid === 1'b1 && exp_q.size() == 0)
      chk("pixel count", 0, 1);
    else if (out_valid === 1'b1)
      chk("pixel", exp_q.pop_front(),
        {out_dispatch, out_ds_early, out_ds_early_write,
         out_use_shader_depth, out_depth_not_less, out_depth_not_greater});
  end
  // ==========================================================
  // main sequence
  initial begin
    logic k;
    logic [3:0] ks;
    void'($urandom(32910));
    repeat (5) @(posedge pclk);
    presetn <= 1;
    rd(32'h0, r);
    chk("cmd rst", 0, r);
    rd(32'h4, r);
    chk("stat rst", 0, r);
    $display("reset test done");
    for (int i = 0; i < 16; i++) begin
      ks = 4'($urandom);
      k = |ks;
      wr(32'h0, u_cs.cmd(ks, i[3:2], i[1:0], 1'b0, 1'b0));
      rd(32'h0, r);
      chk("cmd rb", {6'h0, k, 1'b0, i[3:0], 20'h0}, r);
      chk("state", {k, i[3:0]}, {kill_possible, depth_mode, ds_ctrl});
      repeat (8) pix(k, i[3:2], i[1:0]);
      @(posedge pclk);
      pix_valid <= 0;
      pix_covered <= 1'($urandom);
      pix_ds_pass <= 1'($urandom);
      repeat (3) @(posedge pclk);
      chk("idle", 0, {out_valid, out_dispatch, out_ds_early,
        out_ds_early_write, out_use_shader_depth, out_depth_not_less,
        out_depth_not_greater});
    end
    $display("pixel test done");
    wr(32'h0, u_cs.cmd(4'h0, 2'h2, 2'h0, 1'b1, 1'b1));
    // the write lands at the edge the task returns on; look once settled
    @(negedge pclk);
    chk("viol", 3, {state_violation, rt_indep_raster});
    chk("eff mode", shader_depth_unbounded, depth_mode);
    rd(32'h4, r);
    chk("stat viol", 32'h5, r);
    wr(32'h4, 32'h1);
    rd(32'h4, r);
    chk("stat clr", 32'h4, r);
    wr(32'h0, 0);
    u_cs.xfer(1'b1, 32'h8, 32'hffff_ffff, r, e);
    chk("unmapped err", 1, e);
    rd(32'h0, r);
    chk("unmapped wr", 0, r);
    chk("queue left", 0, exp_q.size());
    $display("register test done");
    test_done();
  end
endmodule : pixel_shader_depth_control_tb
`default_nettype wire
